// >>> pisr_pkg.sv
// constants and carrier types for the phy interrupt and status registers
package pisr_pkg;

    // ------------------------------------------------------------------
    // register indices on the management port
    // ------------------------------------------------------------------
    localparam logic [4:0] FLAG_IDX = 5'h1d;
    localparam logic [4:0] MASK_IDX = 5'h1e;
    localparam logic [4:0] STAT_IDX = 5'h1f;

    // ------------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------------
    localparam int         FLAG_LO      = 1;
    localparam int         FLAG_HI      = 7;
    localparam int         AUTODONE_BIT = 12;
    localparam int         STAT_RSV_LO  = 5;
    localparam int         STAT_RSV_HI  = 11;
    localparam int         SPEED_LO     = 2;
    localparam int         SPEED_HI     = 4;
    localparam logic [6:0] FLAG_RST     = 7'h00;
    localparam logic [6:0] MASK_RST     = 7'h00;
    localparam logic [6:0] STAT_RSV_RST = 7'h02;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ              = 40_000_000;
    localparam int ENERGY_QUIET_MS     = 256;
    localparam int ENERGY_QUIET_CYCLES = ENERGY_QUIET_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       autoneg_done;
        logic       remote_fault;
        logic       link_up;
        logic       partner_ack;
        logic       parallel_fault;
        logic       page_rx;
        logic [2:0] resolved_speed_duplex;
    } pisr_link_s;

    typedef struct packed {
        logic [4:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } pisr_mgmt_s;

endpackage : pisr_pkg

// >>> pisr_regs.sv
// interrupt flag, interrupt mask and special status registers of the transceiver
`timescale 1ns/100ps
`default_nettype none

// Function
// - flag bits 7..1 are read-only, latch high on their event, reset to zero.
// - flag bit 7 sets when energy detection turns on.
// - flag bit 6 sets when auto-negotiation completes.
// - flag bit 5 sets when a remote fault is detected.
// - flag bit 4 sets when link status drops.
// - flag bit 3 sets on link partner acknowledge.
// - flag bit 2 sets on a parallel detection fault.
// - flag bit 1 sets when a page is received.
// - mask bits 7..1 are read-write enables, one enables, reset to zero.
// - status bit 12 reads one only while auto-negotiation is done; reset does not clear it.
// - status bits 11..5 read-write, reset 0000010b; software writes that pattern.
// - status bits 4..2 report resolved speed and duplex code.
// - flag and mask bits 15..8 and bit 0 are read-only.
// - energy status falls after 256 ms quiet; hard reset sets it, soft not.
module pisr_regs
    import pisr_pkg::*;
#(
    parameter int QUIET_CYCLES = ENERGY_QUIET_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    input  wire logic        energy_valid_i,
    input  wire pisr_link_s  link_i,
    input  wire pisr_mgmt_s  mgmt_i,
    output var  logic [15:0] mgmt_rdata_o,
    output var  logic        mgmt_rvalid_o,
    output var  logic        energy_detected_o,
    output var  logic        irq_o
);

    localparam int CW = $clog2(QUIET_CYCLES + 1);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:1]  flags;
    logic [7:1]  mask;
    logic [6:0]  stat_rsv;
    logic        energy_detected;
    logic        energy_prev;
    logic [CW-1:0] quiet_cnt;
    pisr_link_s  link_q;

    // ------------------------------------------------------------------
    // decode and event detection
    // ------------------------------------------------------------------
    wire logic        rd_flag   = mgmt_i.rd && (mgmt_i.addr == FLAG_IDX);
    wire logic        rd_mask   = mgmt_i.rd && (mgmt_i.addr == MASK_IDX);
    wire logic        rd_stat   = mgmt_i.rd && (mgmt_i.addr == STAT_IDX);
    wire logic        wr_mask   = mgmt_i.wr && (mgmt_i.addr == MASK_IDX);
    wire logic        wr_stat   = mgmt_i.wr && (mgmt_i.addr == STAT_IDX);
    wire logic        quiet_end = !energy_valid_i && (quiet_cnt == CW'(QUIET_CYCLES - 1));
    wire logic [7:1]  ev;
    wire logic [7:1]  next_flags;
    wire logic [7:1]  next_mask;
    wire logic [15:0] flag_word;
    wire logic [15:0] mask_word;
    wire logic [15:0] stat_word;
    wire logic [15:0] next_rdata;

    assign ev[7] = energy_detected && !energy_prev;
    assign ev[6] = link_i.autoneg_done && !link_q.autoneg_done;
    assign ev[5] = link_i.remote_fault && !link_q.remote_fault;
    assign ev[4] = !link_i.link_up && link_q.link_up;
    assign ev[3] = link_i.partner_ack;
    assign ev[2] = link_i.parallel_fault;
    assign ev[1] = link_i.page_rx;

    // a set in the cycle of a clearing read wins
    genvar g;
    for (g = FLAG_LO; g <= FLAG_HI; g++) begin : g_flag
        assign next_flags[g] = soft_rst_i ? 1'b0
                             : ev[g] | (flags[g] & ~rd_flag);
    end

    assign next_mask  = soft_rst_i ? MASK_RST
                      : wr_mask ? mgmt_i.wdata[FLAG_HI:FLAG_LO] : mask;

    assign flag_word  = {8'h00, flags, 1'b0};
    assign mask_word  = {8'h00, mask, 1'b0};
    assign stat_word  = {3'h0, link_i.autoneg_done, stat_rsv,
                         link_i.resolved_speed_duplex, 2'h0};
    assign next_rdata = rd_flag ? flag_word
                      : rd_mask ? mask_word
                      : rd_stat ? stat_word : 16'h0000;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags  <= FLAG_RST;
            mask   <= MASK_RST;
            irq_o  <= 1'b0;
            // autoneg_done, remote_fault and link_up levels already standing at release raise no event
            link_q <= link_i;
        end else begin
            flags  <= next_flags;
            mask   <= next_mask;
            irq_o  <= |(next_flags & next_mask);
            link_q <= link_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_rsv <= STAT_RSV_RST;
        end else if (soft_rst_i) begin
            stat_rsv <= STAT_RSV_RST;
        end else if (wr_stat) begin
            stat_rsv <= mgmt_i.wdata[STAT_RSV_HI:STAT_RSV_LO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mgmt_rdata_o  <= 16'h0000;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rdata_o  <= next_rdata;
            mgmt_rvalid_o <= mgmt_i.rd;
        end
    end

    // soft reset deliberately leaves the energy detector alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            energy_detected   <= 1'b1;
            energy_detected_o <= 1'b1;
            energy_prev       <= 1'b1;
            quiet_cnt         <= '0;
        end else begin
            energy_prev <= energy_detected;
            if (energy_valid_i) begin
                quiet_cnt         <= '0;
                energy_detected   <= 1'b1;
                energy_detected_o <= 1'b1;
            end else if (quiet_end) begin
                energy_detected   <= 1'b0;
                energy_detected_o <= 1'b0;
            end else if (energy_detected) begin
                quiet_cnt <= quiet_cnt + CW'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_flag_read_clean(int i);
        rd_flag && !soft_rst_i && flags[i] && !ev[i];
    endsequence

    sequence s_flag_gone(int i);
        !flags[i] ##0 mgmt_rdata_o[i];
    endsequence

    a_flags_reset_zero: assert property ($fell(rst_i) |-> flags == 7'h00 && mask == 7'h00)
        else $error("flags or mask not zero after reset");

    for (g = FLAG_LO; g <= FLAG_HI; g++) begin : g_chk
        a_event_sets_flag: assert property (ev[g] && !soft_rst_i |=> flags[g])
            else $error("event did not latch its flag");
        a_read_clears_flag: assert property (s_flag_read_clean(g) |=> s_flag_gone(g))
            else $error("flag read did not clear the flag");
        a_flag_holds_set: assert property (flags[g] && !rd_flag && !soft_rst_i |=> flags[g])
            else $error("flag dropped without a read");
    end

    a_link_down_flag: assert property ($fell(link_i.link_up) && !soft_rst_i |=> flags[4])
        else $error("link loss not flagged");

    a_irq_follows: assert property (irq_o == |(flags & mask))
        else $error("interrupt request disagrees with enabled flags");

    a_irq_masked: assert property (mask == 7'h00 && !wr_mask |=> !irq_o)
        else $error("interrupt request raised while every source is masked");

    a_mask_write_rd: assert property (wr_mask && !soft_rst_i ##1 rd_mask |=>
                                      mgmt_rdata_o[7:1] == $past(mgmt_i.wdata[7:1], 2))
        else $error("mask write not read back");

    // a mask write, one cycle with no write and no soft reset, then a mask read
    sequence s_mask_settled;
        wr_mask && !soft_rst_i ##1 !wr_mask && !soft_rst_i ##1 rd_mask;
    endsequence

    a_mask_readback: assert property (s_mask_settled |=>
                                      mgmt_rdata_o[7:1] == $past(mgmt_i.wdata[7:1], 3))
        else $error("mask write not read back after an idle cycle");

    a_status_fields: assert property (rd_stat |=>
                                      mgmt_rdata_o[12] == $past(link_i.autoneg_done)
                                      && mgmt_rdata_o[4:2] == $past(link_i.resolved_speed_duplex))
        else $error("status word mismatch");

    a_stat_rsv_reset: assert property ($fell(rst_i) |-> stat_rsv == STAT_RSV_RST)
        else $error("status reserved field reset value wrong");

    a_stat_rsv_write: assert property (wr_stat && !soft_rst_i |=>
                                       stat_rsv == $past(mgmt_i.wdata[STAT_RSV_HI:STAT_RSV_LO]))
        else $error("status reserved field write lost");

    a_reserved_zero: assert property ((rd_flag || rd_mask) |=>
                                      mgmt_rdata_o[15:8] == 8'h00 && !mgmt_rdata_o[0])
        else $error("reserved bits not zero");

    a_energy_quiet: assert property (quiet_end |=>
                                     !energy_detected_o ##1 (!energy_detected_o || $past(energy_valid_i)))
        else $error("energy status did not fall after quiet time");

    // soft reset must not raise a fallen energy status
    a_energy_soft: assert property (soft_rst_i && !energy_valid_i && !energy_detected |=>
                                    !energy_detected)
        else $error("soft reset disturbed energy status");

endmodule : pisr_regs

`default_nettype wire

// >>> pisr_mgmt_host.sv
// station management controller model driving the register port
`timescale 1ns/100ps
`default_nettype none
module pisr_mgmt_host
    import pisr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    output var  pisr_mgmt_s  mgmt_o
);
    initial mgmt_o = '0;
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        mgmt_o.addr  <= a;
        mgmt_o.wdata <= d;
        mgmt_o.wr    <= 1'b1;
        @(posedge clk_i);
        mgmt_o.wr    <= 1'b0;
        // released data must not keep showing the written value
        mgmt_o.wdata <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk_i);
        mgmt_o.addr <= a;
        mgmt_o.rd   <= 1'b1;
        @(posedge clk_i);
        mgmt_o.rd   <= 1'b0;
        #1;
        d  = rdata_i;
        ok = rvalid_i;
    endtask : read_reg
endmodule : pisr_mgmt_host
`default_nettype wire

// >>> pisr_regs_tb.sv
// self-checking testbench for the interrupt flag, mask and status registers
`timescale 1ns/100ps
`default_nettype none
module pisr_regs_tb;
    import pisr_pkg::*;
    logic        clk_i, rst_i, soft_rst_i, energy_valid_i;
    pisr_link_s  link_i;
    pisr_mgmt_s  mgmt_i;
    logic [15:0] mgmt_rdata_o;
    logic        mgmt_rvalid_o, energy_detected_o, irq_o;
    int          fail_count = 0;
    int          cmp_count  = 0;
    pisr_regs #(.QUIET_CYCLES(16)) i_pisr_regs (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .energy_valid_i(energy_valid_i), .link_i(link_i), .mgmt_i(mgmt_i), .mgmt_rdata_o(mgmt_rdata_o),
        .mgmt_rvalid_o(mgmt_rvalid_o), .energy_detected_o(energy_detected_o), .irq_o(irq_o));
    pisr_mgmt_host i_pisr_mgmt_host (.clk_i(clk_i), .rdata_i(mgmt_rdata_o), .rvalid_i(mgmt_rvalid_o),
        .mgmt_o(mgmt_i));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        i_pisr_mgmt_host.read_reg(a, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask : rchk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic scn_reset();
        check({15'h0000, energy_detected_o}, 16'h0001);
        rchk(FLAG_IDX, 16'h0000);
        rchk(MASK_IDX, 16'h0000);
        rchk(STAT_IDX, 16'h0044);
    endtask : scn_reset
    task automatic scn_energy_mask();
        repeat (20) @(posedge clk_i);
        #1 check({15'h0000, energy_detected_o}, 16'h0000);
        @(posedge clk_i);
        energy_valid_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 check({15'h0000, irq_o}, 16'h0000);
        i_pisr_mgmt_host.write_reg(MASK_IDX, 16'hffff);
        rchk(MASK_IDX, 16'h00fe);
        check({15'h0000, irq_o}, 16'h0001);
        i_pisr_mgmt_host.write_reg(FLAG_IDX, 16'hffff);
        rchk(FLAG_IDX, 16'h0080);
        check({15'h0000, irq_o}, 16'h0000);
        rchk(FLAG_IDX, 16'h0000);
    endtask : scn_energy_mask
    task automatic scn_events();
        for (int b = 6; b >= 1; b--) begin
            @(posedge clk_i);
            case (b)
                6: link_i.autoneg_done   <= 1'b1;
                5: link_i.remote_fault   <= 1'b1;
                4: link_i.link_up        <= 1'b0;
                3: link_i.partner_ack    <= 1'b1;
                2: link_i.parallel_fault <= 1'b1;
                default: link_i.page_rx  <= 1'b1;
            endcase
            @(posedge clk_i);
            link_i.partner_ack    <= 1'b0;
            link_i.parallel_fault <= 1'b0;
            link_i.page_rx        <= 1'b0;
            #1 check({15'h0000, irq_o}, 16'h0001);
            rchk(FLAG_IDX, 16'h0001 << b);
            check({15'h0000, irq_o}, 16'h0000);
            rchk(FLAG_IDX, 16'h0000);
        end
    endtask : scn_events
    task automatic scn_status();
        logic [2:0] codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
        i_pisr_mgmt_host.write_reg(STAT_IDX, 16'h0040);
        foreach (codes[i]) begin
            @(posedge clk_i);
            link_i.resolved_speed_duplex <= codes[i];
            rchk(STAT_IDX, {3'h0, 1'b1, 7'h02, codes[i], 2'h0});
        end
    endtask : scn_status
    task automatic scn_resets();
        @(posedge clk_i);
        energy_valid_i <= 1'b0;
        link_i.page_rx <= 1'b1;
        @(posedge clk_i);
        link_i.page_rx <= 1'b0;
        repeat (14) @(posedge clk_i);
        #1 check({15'h0000, energy_detected_o}, 16'h0001);
        @(posedge clk_i);
        #1 check({15'h0000, energy_detected_o}, 16'h0000);
        check({15'h0000, irq_o}, 16'h0001);
        @(posedge clk_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
        #1 check({15'h0000, energy_detected_o}, 16'h0000);
        check({15'h0000, irq_o}, 16'h0000);
        rchk(FLAG_IDX, 16'h0000);
        rchk(MASK_IDX, 16'h0000);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 check({15'h0000, energy_detected_o}, 16'h0001);
        rchk(STAT_IDX, {3'h0, 1'b1, STAT_RSV_RST, 3'h6, 2'h0});
        rchk(FLAG_IDX, 16'h0000);
    endtask : scn_resets
    // ------------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        rst_i          = 1'b1;
        soft_rst_i     = 1'b0;
        energy_valid_i = 1'b0;
        link_i         = '0;
        link_i.link_up = 1'b1;
        link_i.resolved_speed_duplex = 3'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        scn_reset();
        scn_energy_mask();
        scn_events();
        scn_status();
        scn_resets();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
endmodule : pisr_regs_tb
`default_nettype wire
